/* File: hw/cache_line_ctrl.sv */
// data cache line state, victim choice and locked access sequencing
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ps
`include "cache_line_params.svh"
module cache_line_ctrl (
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// core access request
	input wire logic core_req_valid,
	input wire logic core_req_write,
	input wire logic core_req_cacheable,
	input wire logic core_req_page_wt,
	input wire logic [`CL_SET_BITS-1:0] core_req_set,
	input wire logic [3:0] core_req_tag_match,
	input wire logic core_lock_begin,
	input wire logic core_unlock,
	output logic core_ready,
	output logic core_done,
	output logic core_use_bus_data,
	output logic [1:0] core_fill_way,
	output logic core_fill_valid,
	// system bus pins
	input wire logic write_policy_input,
	input wire logic next_address_request_n,
	input wire logic burst_ready_n,
	input wire logic cache_enable_input_n,
	output logic bus_start,
	output logic bus_write,
	output logic bus_line,
	output logic bus_lock,
	output logic bus_writeback,
	// inquiry port
	input wire logic inq_valid,
	input wire logic inquiry_invalidate,
	input wire logic [`CL_SET_BITS-1:0] inq_set,
	input wire logic [3:0] inq_tag_match,
	output logic inq_hit,
	output logic inq_hitm,
	output logic inq_writeback,
	// invalidate-all strobe to the tag logic
	output logic invalidate_all_pulse
);
	// ------------------------------------------------------------
	// storage and control state
	// ------------------------------------------------------------
	cache_line_pkg::line_state_t line_state_reg [`CL_SET_COUNT][`CL_WAY_COUNT]; // per line
	cache_line_pkg::ctrl_state_t st_reg; // sequencer
	logic [2:0] pin_sync_reg [4]; // three-stage pin synchronisers
	logic [3:0] pin_filt_reg; // agreed pin levels
	logic repl_mode_reg; // non-random mode
	logic [1:0] repl_way_reg; // software victim way
	logic inval_req_reg; // counter clear strobe
	logic [1:0] victim_reg; // last victim chosen
	logic lock_region_reg; // inside lock region
	logic unlock_seen_reg; // unlock executed, one more access locked
	logic [`CL_SET_BITS-1:0] a_set_reg; // latched access
	logic [3:0] a_match_reg;
	logic a_write_reg, a_cache_reg, a_wt_reg, a_lock_reg;
	logic a_hit_reg; // hit at decide time
	logic [1:0] a_way_reg; // hit way
	logic [2:0] beats_reg; // ready pulses still due
	logic first_seen_reg; // policy already sampled this cycle
	logic policy_reg; // sampled policy level
	logic alloc_reg; // fill allowed by cache enable
	logic demoted_reg; // inquiry demoted the locked dirty line
	logic [1:0] c_way_reg; // way written at commit
	cache_line_pkg::line_event_t c_event_reg; // event applied at commit
	// ------------------------------------------------------------
	// pin inputs: a change counts once stages two and three agree
	// ------------------------------------------------------------
	logic [3:0] pin_raw;
	assign pin_raw = {cache_enable_input_n, burst_ready_n, next_address_request_n,
		write_policy_input};
	genvar p;
	generate
		for (p = 0; p < 4; p++)
		begin : g_pin
			always_ff @(posedge sys_clk or posedge sys_rst)
			begin
				if (sys_rst)
				begin
					pin_sync_reg[p] <= (p == 0) ? 3'h0 : 3'h7; // idle levels: no false strobe at release
					pin_filt_reg[p] <= (p == 0) ? 1'b0 : 1'b1; // bus strobes idle high
				end
				else
				begin
					pin_sync_reg[p] <= {pin_sync_reg[p][1:0], pin_raw[p]};
					if (pin_sync_reg[p][1] == pin_sync_reg[p][2])
						pin_filt_reg[p] <= pin_sync_reg[p][2];
				end
			end
		end
	endgenerate
	logic policy_pin, na_seen, ready_seen, ken_seen;
	assign policy_pin = pin_filt_reg[0];
	assign na_seen = !pin_filt_reg[1];
	assign ready_seen = !pin_filt_reg[2];
	assign ken_seen = !pin_filt_reg[3];
	// ------------------------------------------------------------
	// set views and helpers
	// ------------------------------------------------------------
	logic [3:0] set_valid, inq_valid_ways;
	genvar w;
	generate
		for (w = 0; w < `CL_WAY_COUNT; w++)
		begin : g_way
			// only invalid counts as not valid
			assign set_valid[w] = line_state_reg[a_set_reg][w] != cache_line_pkg::LINE_I;
			assign inq_valid_ways[w] = line_state_reg[inq_set][w] != cache_line_pkg::LINE_I;
		end
	endgenerate
	logic [3:0] hit_ways, inq_hits;
	logic [1:0] hit_way, inq_way, victim_way, counter_value;
	assign hit_ways = a_match_reg & set_valid;
	assign inq_hits = inq_tag_match & inq_valid_ways;
	assign hit_way = hit_ways[3] ? 2'h3 : hit_ways[2] ? 2'h2 : hit_ways[1] ? 2'h1 : 2'h0;
	assign inq_way = inq_hits[3] ? 2'h3 : inq_hits[2] ? 2'h2 : inq_hits[1] ? 2'h1 : 2'h0;
	cache_line_pkg::line_state_t hit_state, inq_state, c_state;
	assign hit_state = line_state_reg[a_set_reg][hit_way];
	assign inq_state = line_state_reg[inq_set][inq_way];
	assign c_state = line_state_reg[a_set_reg][c_way_reg];
	// ------------------------------------------------------------
	// submodules
	// ------------------------------------------------------------
	victim_select u_victim (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.counter_clear(inval_req_reg),
		.way_valid(set_valid),
		.replacement_control(repl_mode_reg),
		.replacement_way_select(repl_way_reg),
		.victim_way(victim_way),
		.counter_value(counter_value)
	);
	cache_line_pkg::line_state_t c_next, inq_next;
	// policy ignored on write-through pages
	line_state_next u_commit_next (
		.cur_state(c_state),
		.line_event(c_event_reg),
		.policy_high(policy_reg && !a_wt_reg),
		.inquiry_invalidate(1'b0),
		.next_state(c_next)
	);
	line_state_next u_inq_next (
		.cur_state(inq_state),
		.line_event(cache_line_pkg::EV_INQUIRY),
		.policy_high(1'b0),
		.inquiry_invalidate(inquiry_invalidate),
		.next_state(inq_next)
	);
	// ------------------------------------------------------------
	// line state array: inquiry owns the write port in its cycle
	// ------------------------------------------------------------
	logic commit_go;
	assign commit_go = (st_reg == cache_line_pkg::ST_COMMIT || st_reg == cache_line_pkg::ST_EVICT)
		&& !inq_valid;
	genvar s;
	generate
		for (s = 0; s < `CL_SET_COUNT; s++)
		begin : g_set
			always_ff @(posedge sys_clk or posedge sys_rst)
			begin
				if (sys_rst)
					for (int k = 0; k < `CL_WAY_COUNT; k++)
						line_state_reg[s][k] <= cache_line_pkg::LINE_I;
				else if (inq_valid && |inq_hits && inq_set == s)
					line_state_reg[s][inq_way] <= inq_next;
				else if (commit_go && a_set_reg == s)
					line_state_reg[s][c_way_reg] <= (st_reg == cache_line_pkg::ST_EVICT) ?
						cache_line_pkg::LINE_I : c_next;
			end
		end
	endgenerate
	// ------------------------------------------------------------
	// inquiry answer, one cycle after the probe
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			inq_hit <= 1'b0;
			inq_hitm <= 1'b0;
			inq_writeback <= 1'b0;
		end
		else
		begin
			inq_hit <= inq_valid && |inq_hits;
			inq_hitm <= inq_valid && |inq_hits && inq_state == cache_line_pkg::LINE_M;
			// dirty line is pushed out in either inquiry flavour
			inq_writeback <= inq_valid && |inq_hits && inq_state == cache_line_pkg::LINE_M;
		end
	end
	// ------------------------------------------------------------
	// lock region tracking
	// ------------------------------------------------------------
	logic take;
	assign take = core_req_valid && core_ready;
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			lock_region_reg <= 1'b0;
			unlock_seen_reg <= 1'b0;
		end
		else if (take && unlock_seen_reg)
		begin
			// the first access past the unlock is still locked
			lock_region_reg <= 1'b0;
			unlock_seen_reg <= 1'b0;
		end
		else if (core_lock_begin)
			lock_region_reg <= 1'b1;
		else if (core_unlock && lock_region_reg)
			unlock_seen_reg <= 1'b1;
	end
	// ------------------------------------------------------------
	// access sequencer
	// ------------------------------------------------------------
	// one access in flight: later loads and stores wait for the last ready,
	// which orders misses ahead of locked ones and locked ones ahead of the rest
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st_reg <= cache_line_pkg::ST_IDLE;
			core_ready <= 1'b0;
			core_done <= 1'b0;
			core_use_bus_data <= 1'b0;
			core_fill_way <= 2'h0;
			core_fill_valid <= 1'b0;
			bus_start <= 1'b0;
			bus_write <= 1'b0;
			bus_line <= 1'b0;
			bus_lock <= 1'b0;
			bus_writeback <= 1'b0;
			a_set_reg <= '0;
			a_match_reg <= 4'h0;
			a_write_reg <= 1'b0;
			a_cache_reg <= 1'b0;
			a_wt_reg <= 1'b0;
			a_lock_reg <= 1'b0;
			a_hit_reg <= 1'b0;
			a_way_reg <= 2'h0;
			beats_reg <= 3'h0;
			first_seen_reg <= 1'b0;
			policy_reg <= 1'b0;
			alloc_reg <= 1'b0;
			demoted_reg <= 1'b0;
			c_way_reg <= 2'h0;
			c_event_reg <= cache_line_pkg::EV_WRITE;
			victim_reg <= 2'h0;
		end
		else
		begin
			core_done <= 1'b0;
			core_fill_valid <= 1'b0;
			bus_start <= 1'b0;
			case (st_reg)
				cache_line_pkg::ST_IDLE:
				begin
					core_ready <= 1'b1;
					if (take)
					begin
						core_ready <= 1'b0;
						a_set_reg <= core_req_set;
						a_match_reg <= core_req_tag_match;
						a_write_reg <= core_req_write;
						a_cache_reg <= core_req_cacheable;
						a_wt_reg <= core_req_page_wt;
						a_lock_reg <= lock_region_reg || core_lock_begin;
						st_reg <= cache_line_pkg::ST_DECIDE;
					end
				end
				cache_line_pkg::ST_DECIDE:
				begin
					a_hit_reg <= |hit_ways;
					a_way_reg <= hit_way;
					c_way_reg <= hit_way;
					first_seen_reg <= 1'b0;
					demoted_reg <= 1'b0;
					alloc_reg <= 1'b0;
					core_use_bus_data <= 1'b1;
					if (!a_write_reg && |hit_ways && !a_lock_reg)
					begin
						// plain read hit, no bus
						core_use_bus_data <= 1'b0;
						core_done <= 1'b1;
						st_reg <= cache_line_pkg::ST_IDLE;
					end
					else if (a_write_reg && |hit_ways && !a_lock_reg && !a_wt_reg &&
						hit_state != cache_line_pkg::LINE_S)
					begin
						// dirty or exclusive hit stays inside
						c_event_reg <= cache_line_pkg::EV_WRITE;
						st_reg <= cache_line_pkg::ST_COMMIT;
					end
					else
					begin
						// every other access, and every locked one, uses the bus
						bus_start <= 1'b1;
						bus_write <= a_write_reg;
						bus_line <= !a_write_reg && !(|hit_ways) && a_cache_reg;
						bus_lock <= a_lock_reg;
						bus_writeback <= 1'b0;
						beats_reg <= (!a_write_reg && !(|hit_ways) && a_cache_reg) ?
							`CL_LINE_BEATS : `CL_SINGLE_BEATS;
						c_event_reg <= a_write_reg ? (a_lock_reg ?
							cache_line_pkg::EV_LOCKED_WRITE : cache_line_pkg::EV_WRITE) :
							cache_line_pkg::EV_READ_FILL;
						st_reg <= cache_line_pkg::ST_BUS;
					end
				end
				cache_line_pkg::ST_BUS:
				begin
					// policy and cache enable caught at next-address or first ready
					if (!first_seen_reg && (na_seen || ready_seen))
					begin
						first_seen_reg <= 1'b1;
						policy_reg <= policy_pin;
						alloc_reg <= ken_seen && a_cache_reg && bus_line;
					end
					// inquiry that demotes the locked dirty line before its ready
					if (inq_valid && |inq_hits && inq_set == a_set_reg && inq_way == a_way_reg &&
						!ready_seen)
						demoted_reg <= 1'b1;
					if (ready_seen)
					begin
						beats_reg <= beats_reg - 3'h1;
						if (beats_reg == 3'h1)
						begin
							if (bus_writeback)
								st_reg <= cache_line_pkg::ST_EVICT;
							else if (!a_write_reg && a_hit_reg)
							begin
								// dirty line wins unless an inquiry pushed it out
								core_use_bus_data <= demoted_reg ||
									hit_state != cache_line_pkg::LINE_M;
								core_done <= 1'b1;
								st_reg <= cache_line_pkg::ST_IDLE;
							end
							else if (!a_write_reg && !alloc_reg &&
								!(!first_seen_reg && ken_seen && a_cache_reg && bus_line))
							begin
								core_done <= 1'b1;
								st_reg <= cache_line_pkg::ST_IDLE;
							end
							else if (!a_write_reg)
							begin
								// fill: pick the victim now, write it back when dirty
								victim_reg <= victim_way;
								c_way_reg <= victim_way;
								if (line_state_reg[a_set_reg][victim_way] == cache_line_pkg::LINE_M)
								begin
									bus_start <= 1'b1;
									bus_write <= 1'b1;
									bus_line <= 1'b1;
									bus_writeback <= 1'b1;
									beats_reg <= `CL_LINE_BEATS;
									st_reg <= cache_line_pkg::ST_WBACK;
								end
								else
									st_reg <= cache_line_pkg::ST_COMMIT;
							end
							else if (a_hit_reg)
								st_reg <= cache_line_pkg::ST_COMMIT;
							else
							begin
								// write miss never allocates
								core_done <= 1'b1;
								st_reg <= cache_line_pkg::ST_IDLE;
							end
						end
					end
				end
				cache_line_pkg::ST_WBACK:
					st_reg <= cache_line_pkg::ST_BUS;
				cache_line_pkg::ST_EVICT:
				begin
					if (commit_go)
					begin
						bus_writeback <= 1'b0;
						st_reg <= cache_line_pkg::ST_COMMIT;
					end
				end
				cache_line_pkg::ST_COMMIT:
				begin
					// waits while an inquiry holds the write port
					if (commit_go)
					begin
						core_done <= 1'b1;
						core_fill_valid <= !a_write_reg;
						core_fill_way <= c_way_reg;
						st_reg <= cache_line_pkg::ST_IDLE;
					end
				end
				default: st_reg <= cache_line_pkg::ST_IDLE;
			endcase
		end
	end
	// ------------------------------------------------------------
	// wishbone register file
	// ------------------------------------------------------------
	logic wb_hit;
	assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			repl_mode_reg <= `CL_REPL_MODE_RESET;
			repl_way_reg <= `CL_REPL_WAY_RESET;
			inval_req_reg <= 1'b0;
			invalidate_all_pulse <= 1'b0;
		end
		else
		begin
			wb_ack_o <= wb_hit;
			inval_req_reg <= 1'b0;
			invalidate_all_pulse <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			if (wb_hit && wb_we_i && wb_adr_i == `CL_REG_REPL_CTRL)
			begin
				if (wb_sel_i[0])
					repl_mode_reg <= wb_dat_i[`CL_REPL_MODE_BIT];
				if (wb_sel_i[0])
					repl_way_reg <= wb_dat_i[`CL_REPL_WAY_MSB:`CL_REPL_WAY_LSB];
				// self-clearing: also clears the replacement counters
				if (wb_sel_i[1] && wb_dat_i[`CL_REPL_INVAL_BIT])
				begin
					inval_req_reg <= 1'b1;
					invalidate_all_pulse <= 1'b1;
				end
			end
			else if (wb_hit && !wb_we_i && wb_adr_i == `CL_REG_REPL_CTRL)
			begin
				wb_dat_o[`CL_REPL_MODE_BIT] <= repl_mode_reg;
				wb_dat_o[`CL_REPL_WAY_MSB:`CL_REPL_WAY_LSB] <= repl_way_reg;
			end
			else if (wb_hit && !wb_we_i && wb_adr_i == `CL_REG_STATUS)
			begin
				wb_dat_o[`CL_STAT_VICTIM_MSB:`CL_STAT_VICTIM_LSB] <= victim_reg;
				wb_dat_o[`CL_STAT_COUNT_MSB:`CL_STAT_COUNT_LSB] <= counter_value;
				wb_dat_o[`CL_STAT_LOCK_BIT] <= lock_region_reg;
				wb_dat_o[`CL_STAT_BUSY_BIT] <= st_reg != cache_line_pkg::ST_IDLE;
			end
		end
	end
endmodule // cache_line_ctrl

/* File: hw/cache_line_params.svh */
// constants of the data cache line state and replacement controller
`ifndef CACHE_LINE_PARAMS_SVH
`define CACHE_LINE_PARAMS_SVH
// ------------------------------------------------------------
// geometry
// ------------------------------------------------------------
`define CL_SET_BITS 7
`define CL_SET_COUNT 128
`define CL_WAY_COUNT 4
`define CL_LINE_BEATS 3'h4
`define CL_SINGLE_BEATS 3'h1
// ------------------------------------------------------------
// register map (byte addresses on the wishbone bus)
// ------------------------------------------------------------
`define CL_REG_REPL_CTRL 4'h0
`define CL_REG_STATUS 4'h4
// replacement control register fields
`define CL_REPL_MODE_BIT 0
`define CL_REPL_WAY_LSB 4
`define CL_REPL_WAY_MSB 5
`define CL_REPL_INVAL_BIT 8
`define CL_REPL_MODE_RESET 1'h0
`define CL_REPL_WAY_RESET 2'h0
// status register fields
`define CL_STAT_VICTIM_LSB 0
`define CL_STAT_VICTIM_MSB 1
`define CL_STAT_COUNT_LSB 2
`define CL_STAT_COUNT_MSB 3
`define CL_STAT_LOCK_BIT 4
`define CL_STAT_BUSY_BIT 5
`define CL_COUNTER_RESET 2'h0
`endif

/* File: hw/cache_line_pkg.sv */
// types shared by the cache line state and replacement controller
package cache_line_pkg;
	// line coherence state, invalid first so a cleared array reads invalid
	typedef enum logic [1:0] {LINE_I, LINE_S, LINE_E, LINE_M} line_state_t;
	// internal and external events that move a line
	typedef enum logic [2:0] {EV_READ_FILL, EV_WRITE, EV_VICTIM, EV_INQUIRY, EV_LOCKED_WRITE}
		line_event_t;
	// controller sequence
	typedef enum logic [2:0] {ST_IDLE, ST_DECIDE, ST_BUS, ST_WBACK, ST_EVICT, ST_COMMIT}
		ctrl_state_t;
endpackage

/* File: hw/line_state_next.sv */
// next coherence state of one line for a given event
`timescale 1ns/1ps
module line_state_next (
	// present state and event
	input cache_line_pkg::line_state_t cur_state,
	input cache_line_pkg::line_event_t line_event,
	// qualifiers
	input logic policy_high,
	input logic inquiry_invalidate,
	// result
	output cache_line_pkg::line_state_t next_state
);
	// ------------------------------------------------------------
	// transition table
	// ------------------------------------------------------------
	always_comb
	begin
		next_state = cur_state;
		case (line_event)
			// filled line enters e or s by the sampled policy
			cache_line_pkg::EV_READ_FILL: next_state = policy_high ? cache_line_pkg::LINE_E :
				cache_line_pkg::LINE_S;
			cache_line_pkg::EV_WRITE:
			begin
				if (cur_state == cache_line_pkg::LINE_S)
					next_state = policy_high ? cache_line_pkg::LINE_E : cache_line_pkg::LINE_S;
				else if (cur_state == cache_line_pkg::LINE_E)
					next_state = cache_line_pkg::LINE_M;
			end
			// write-back on replacement only empties the line
			cache_line_pkg::EV_VICTIM: next_state = cache_line_pkg::LINE_I;
			cache_line_pkg::EV_INQUIRY:
			begin
				if (inquiry_invalidate)
					next_state = cache_line_pkg::LINE_I;
				else if (cur_state == cache_line_pkg::LINE_E || cur_state == cache_line_pkg::LINE_M)
					next_state = cache_line_pkg::LINE_S;
			end
			// short locked store makes any valid line dirty
			cache_line_pkg::EV_LOCKED_WRITE: next_state = (cur_state == cache_line_pkg::LINE_I) ?
				cache_line_pkg::LINE_I : cache_line_pkg::LINE_M;
			default: next_state = cur_state;
		endcase
	end
endmodule // line_state_next

/* File: hw/victim_select.sv */
// victim way choice: software way when selected, else invalid first, then counter
`timescale 1ns/1ps
`include "cache_line_params.svh"
module victim_select (
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// counter control
	input wire logic counter_clear,
	// set view and mode
	input wire logic [3:0] way_valid,
	input wire logic replacement_control,
	input wire logic [1:0] replacement_way_select,
	// choice
	output logic [1:0] victim_way,
	output logic [1:0] counter_value
);
	logic [1:0] count_reg; // pseudorandom source
	// ------------------------------------------------------------
	// replacement counter
	// ------------------------------------------------------------
	// free running, so the choice repeats exactly from a known start
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			count_reg <= `CL_COUNTER_RESET;
		else if (counter_clear)
			count_reg <= `CL_COUNTER_RESET;
		else
			count_reg <= count_reg + 2'h1;
	end
	assign counter_value = count_reg;
	// ------------------------------------------------------------
	// choice
	// ------------------------------------------------------------
	always_comb
	begin
		victim_way = count_reg;
		if (replacement_control)
			victim_way = replacement_way_select;
		else if (!way_valid[0])
			victim_way = 2'h0;
		else if (!way_valid[1])
			victim_way = 2'h1;
		else if (!way_valid[2])
			victim_way = 2'h2;
		else if (!way_valid[3])
			victim_way = 2'h3;
	end
endmodule // victim_select

/* File: verification/cache_line_ctrl_tb_top.sv */
// self-checking bench of the cache line controller with queued expectations
`timescale 1ns/1ps
module cache_line_ctrl_tb_top;
	logic sys_clk = 1'h0, sys_rst = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
	logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0, core_req_tag_match = 4'h0, inq_tag_match = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rnd = 32'h4176_3a4d;
	logic core_req_valid = 1'h0, core_req_write = 1'h0, inq_valid = 1'h0, inquiry_invalidate = 1'h0;
	logic core_req_cacheable = 1'h1, core_req_page_wt = 1'h0, core_lock_begin = 1'h0;
	logic core_unlock = 1'h0;
	logic [6:0] core_req_set = 7'h00, inq_set = 7'h00;
	logic wb_ack_o, core_ready, core_done, core_use_bus_data, core_fill_valid, bus_start, bus_write;
	logic bus_line, bus_lock, bus_writeback, inq_hit, inq_hitm, inq_writeback, invalidate_all_pulse;
	logic write_policy_input, next_address_request_n, burst_ready_n, cache_enable_input_n;
	logic [1:0] core_fill_way;
	logic [33:0] notes [$];
	int fail_count = 0, checks_done = 0, cycles = 0, starts = 0;
	cache_line_ctrl uut (.*);
	sys_bus_model bus (.*);
	initial forever #20 sys_clk = ~sys_clk;
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
			fail_count++;
		end
	endtask
	task automatic stop_test;
		if (fail_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// classic single wishbone cycle, held until ack is sampled
	task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, we, a, 4'hf, d};
		do @(posedge sys_clk); while (wb_ack_o !== 1'h1);
		{wb_cyc_i, wb_stb_i} <= 2'h0;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		notes.push_back({2'h0, e});
		rnd = xs(rnd);
		wb(1'h0, a, rnd);
	endtask
	// one core access; bus cycles it caused are compared with nb
	task automatic access(input logic w, input logic [3:0] m, input logic [33:0] n, input int nb);
		int b0;
		do @(posedge sys_clk); while (core_ready !== 1'h1);
		b0 = starts;
		if (n[33:32] == 2'h1) notes.push_back(n);
		{core_req_valid, core_req_write, core_req_tag_match} <= {1'h1, w, m};
		@(posedge sys_clk);
		core_req_valid <= 1'h0;
		do @(posedge sys_clk); while (core_done !== 1'h1);
		check("bus cycles", 34'(starts - b0), 34'(nb));
		if (n[33:32] == 2'h3) check("bus data", 34'(core_use_bus_data), 34'(n[2]));
		if (nb > 0) check("bus lock", 34'(bus_lock), 34'(n[3]));
	endtask
	task automatic probe(input logic [3:0] m, input logic i, input logic [1:0] e);
		notes.push_back({2'h2, 30'h0, e});
		@(posedge sys_clk);
		{inq_valid, inq_tag_match, inquiry_invalidate} <= {1'h1, m, i};
		@(posedge sys_clk);
		inq_valid <= 1'h0;
		repeat (3) @(posedge sys_clk);
	endtask
	task automatic take(input string s, input logic [33:0] v);
		check(s, v, notes.size() > 0 ? notes.pop_front() : ~v);
	endtask
	// watcher: oldest note against each result that appears
	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		starts <= starts + (bus_start === 1'h1);
		if (wb_ack_o === 1'h1 && wb_we_i === 1'h0) take("read data", {2'h0, wb_dat_o});
		if (core_fill_valid === 1'h1) take("fill", {2'h1, 29'h0, core_use_bus_data, core_fill_way});
		if (inq_hit === 1'h1) take("inquiry", {2'h2, 30'h0, inq_hitm, inq_writeback});
		if (cycles == 20000)
		begin
			fail_count++;
			stop_test;
		end
	end
	initial
	begin
		rnd = xs(rnd);
		core_req_set = rnd[6:0];
		inq_set = rnd[6:0];
		repeat (20) @(posedge sys_clk);
		sys_rst <= 1'h0;
		repeat (4) @(posedge sys_clk);
		rd(4'h0, 32'h0000_0000);
		wb(1'h1, 4'hc, rnd);
		rd(4'hc, 32'h0000_0000);
		for (int w = 0; w < 4; w++) access(1'h0, 4'h0, {2'h1, 29'h0, 1'h1, 2'(w)}, 1);
		wb(1'h1, 4'h0, 32'h0000_0021);
		rd(4'h0, 32'h0000_0021);
		access(1'h0, 4'h0, {2'h1, 29'h0, 3'h6}, 1);
		probe(4'h1, 1'h1, 2'h0);
		wb(1'h1, 4'h0, 32'h0000_0100);
		rd(4'h4, 32'h0000_000a);
		access(1'h0, 4'h0, {2'h1, 29'h0, 3'h4}, 1);
		access(1'h1, 4'h2, 34'h0, 1);
		access(1'h1, 4'h2, 34'h0, 0);
		core_lock_begin <= 1'h1;
		access(1'h0, 4'h2, {2'h3, 29'h1, 3'h0}, 1);
		{core_lock_begin, core_unlock} <= 2'h1;
		access(1'h1, 4'h2, 34'h8, 1);
		core_unlock <= 1'h0;
		access(1'h1, 4'h2, 34'h0, 0);
		probe(4'h2, 1'h0, 2'h3);
		probe(4'h2, 1'h0, 2'h0);
		check("notes left", 34'(notes.size()), 34'h0);
		stop_test;
	end
endmodule // cache_line_ctrl_tb_top

/* File: verification/cache_line_props.sv */
// port timing checker of the cache line controller
`timescale 1ns/1ps
module cache_line_props (
	input wire logic sys_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
	input wire logic [3:0] wb_adr_i, wb_sel_i,
	input wire logic [31:0] wb_dat_i, wb_dat_o,
	input wire logic core_req_valid, core_ready, core_done, inq_valid, inq_hit,
	input wire logic inq_hitm, inq_writeback, invalidate_all_pulse
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing");
	dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("dat not 0");
	ready_drop_a: assert property (core_req_valid && core_ready |=> !core_ready)
		else $error("ready held");
	ready_back_a: assert property (core_done |=> core_ready) else $error("ready late");
	hit_probe_a: assert property (inq_hit |-> $past(inq_valid)) else $error("hit unasked");
	dirty_writeback_a: assert property (inq_writeback == inq_hitm && (!inq_hitm || inq_hit))
		else $error("writeback mismatch");
	inval_clear_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i &&
		wb_adr_i == 4'h0 && wb_sel_i[1] && wb_dat_i[8] |-> ##[1:2] invalidate_all_pulse)
		else $error("no invalidate pulse");
endmodule // cache_line_props
bind cache_line_ctrl cache_line_props chk (.*);

/* File: verification/sys_bus_model.sv */
// behavioural system bus answering each bus cycle with its beats
`timescale 1ns/1ps
module sys_bus_model (
	input wire logic sys_clk, bus_start, bus_write, bus_line,
	output logic write_policy_input, next_address_request_n, burst_ready_n, cache_enable_input_n
);
	// idle policy and cache enable pins toggle so a stale level is never mistaken for an answer
	initial
	begin
		{write_policy_input, next_address_request_n, burst_ready_n, cache_enable_input_n} = 4'h6;
		forever
		begin
			@(posedge sys_clk);
			if (bus_start === 1'h1)
			begin
				repeat (2) @(posedge sys_clk);
				write_policy_input <= bus_write;
				cache_enable_input_n <= 1'h0;
				// the pin filter drops a one-clock low, so a single beat stands two clocks
				repeat (bus_line ? 4 : 2)
				begin
					burst_ready_n <= 1'h0;
					@(posedge sys_clk);
				end
				burst_ready_n <= 1'h1;
			end
			else
				{write_policy_input, cache_enable_input_n} <= ~{write_policy_input, cache_enable_input_n};
		end
	end
endmodule // sys_bus_model
